// >>> hw/fws_defines.svh
// Constants for the flash write-status polling controller.
`ifndef FWS_DEFINES_SVH
`define FWS_DEFINES_SVH
// Register offsets on the software port.
`define FWS_REG_CTRL 4'h0
`define FWS_REG_ADDR 4'h1
`define FWS_REG_STATUS 4'h2
`define FWS_REG_IRQ 4'h3
`define FWS_REG_MASK 4'h4
`define FWS_REG_LAST 4'h5
// Control register fields.
`define FWS_CTRL_START 0
`define FWS_CTRL_ERASE 1
`define FWS_CTRL_ADD_SECTOR 2
`define FWS_CTRL_ABORT 3
// Status bit positions on the data bus.
`define FWS_BIT_POLL 7
`define FWS_BIT_TOG1 6
`define FWS_BIT_TIMEOUT 5
`define FWS_BIT_ETIMER 3
`define FWS_BIT_TOG2 2
// Interrupt bits.
`define FWS_IRQ_DONE 0
`define FWS_IRQ_FAIL 1
`define FWS_IRQ_REJECT 2
`define FWS_IRQ_WIDTH 3
// Flash read and write strobe timing, in ns, and derived cycle counts.
`define FWS_T_STROBE_NS 200
`define FWS_STROBE_CYC (((`FWS_T_STROBE_NS) + 99) / 100)
// Reset and sector erase command words.
`define FWS_RESET_DATA 16'h00f0
`define FWS_SECTOR_ERASE_DATA 16'h0030
`endif

// >>> hw/fws_pkg.sv
// Types shared by the flash write-status polling controller.
package fws_pkg;
  typedef enum logic [1:0] {
    fws_res_busy,
    fws_res_done,
    fws_res_fail,
    fws_res_reject
  } fws_result_t;
endpackage : fws_pkg

// >>> hw/fws_bus_cycle.sv
// One flash bus cycle (read or write) with fixed strobe width.
`timescale 1ns/1ps
`include "fws_defines.svh"
module fws_bus_cycle #(
  parameter int ADDR_W = 22,
  parameter int DATA_W = 16,
  parameter int STROBE_CYC = `FWS_STROBE_CYC
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic go,
  input wire logic is_write,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  output logic done,
  output logic [DATA_W-1:0] rdata,
  output logic [ADDR_W-1:0] flash_addr,
  output logic chip_select_n,
  output logic output_enable_n,
  output logic write_strobe_n,
  output logic [DATA_W-1:0] data_bus_out,
  output logic data_bus_oe_n,
  input wire logic [DATA_W-1:0] data_bus_in
);
  logic [7:0] count;
  logic [7:0] next_count;
  logic busy;
  logic next_busy;
  logic wr;
  logic next_wr;
  logic next_done;
  logic [DATA_W-1:0] next_rdata;
  logic [ADDR_W-1:0] next_flash_addr;
  logic [DATA_W-1:0] next_data_bus_out;

  // Each cycle holds its strobe low for the strobe time, then releases it; the rising
  // edge of the strobe ends the cycle, which is where reads are sampled.
  always_comb begin
    next_count = count;
    next_busy = busy;
    next_wr = wr;
    next_done = 1'b0;
    next_rdata = rdata;
    next_flash_addr = flash_addr;
    next_data_bus_out = data_bus_out;
    if (!busy && go) begin
      next_busy = 1'b1;
      next_wr = is_write;
      next_count = 8'(STROBE_CYC);
      next_flash_addr = addr;
      next_data_bus_out = wdata;
    end else if (busy) begin
      if (count == 8'h01) begin
        next_busy = 1'b0;
        next_done = 1'b1;
        if (!wr) begin
          next_rdata = data_bus_in;
        end
      end
      next_count = count - 8'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= 8'h00;
      busy <= 1'b0;
      wr <= 1'b0;
      done <= 1'b0;
      rdata <= '0;
      flash_addr <= '0;
      data_bus_out <= '0;
      chip_select_n <= 1'b1;
      output_enable_n <= 1'b1;
      write_strobe_n <= 1'b1;
      data_bus_oe_n <= 1'b1;
    end else begin
      count <= next_count;
      busy <= next_busy;
      wr <= next_wr;
      done <= next_done;
      rdata <= next_rdata;
      flash_addr <= next_flash_addr;
      data_bus_out <= next_data_bus_out;
      chip_select_n <= !next_busy;
      output_enable_n <= !(next_busy && !next_wr);
      write_strobe_n <= !(next_busy && next_wr);
      data_bus_oe_n <= !(next_busy && next_wr);
    end
  end
endmodule : fws_bus_cycle

// >>> hw/fws_ctrl.sv
// Host controller that polls flash write-operation status bits.
//
// Contract
// RQ1: Device toggles toggle_bit_two on reads inside erase-selected sectors.
// RQ2: toggle_bit_two valid from rising edge of the last write strobe.
// RQ3: toggle_bit_one gives mode, toggle_bit_two gives sector; both needed. The code reads only toggle_bit_two in erase mode, else toggle_bit_one.
// RQ4: Host reads twice, compares toggle bit; unchanged means done.
// RQ5: Still toggling: check timeout flag, re-test, fail means reset command.
// RQ6: Host returning from other work restarts with a fresh double read.
// RQ7: Device sets timeout_flag_bit when pulse count limit is exceeded.
// RQ8: Programming 0 to 1 halts and sets timeout_flag_bit.
// RQ9: After timeout failure the host issues the reset command; an abort taken as the failing fourth read ends skips it.
// RQ10: erase_timer_bit is 0 during acceptance window, then 1; restarts per command.
// RQ11: Host sending added sectors under 50 us may skip the timer check.
// RQ12: Once erase_timer_bit is 1 only erase suspend is accepted.
// RQ13: Host confirms acceptance, then checks erase_timer_bit before and after.
// RQ14: erase_timer_bit high at second check means command may be rejected; the code rejects only while ready_busy_pin is also low.
// RQ15: During erase: polling 0, toggle_bit_one toggles, timeout 0, timer 1.
// RQ16: Non-busy bank returns array data; host must address the busy bank.
// RQ17: Host must supply a valid program or erase-selected address.
// RQ18: toggle_bit_one inverts on each read while an operation runs.
// RQ19: ready_busy_out low while programming or erasing.
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "fws_defines.svh"
module fws_ctrl #(
  parameter int ADDR_W = 22,
  parameter int DATA_W = 16
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output logic irq,
  output logic [ADDR_W-1:0] flash_addr,
  output logic chip_select_n,
  output logic output_enable_n,
  output logic write_strobe_n,
  output logic [DATA_W-1:0] data_bus_out,
  output logic data_bus_oe_n,
  input wire logic [DATA_W-1:0] data_bus_in,
  input wire logic ready_busy_pin
);
  typedef enum logic [3:0] {
    st_idle,
    st_read_first,
    st_read_second,
    st_read_third,
    st_read_fourth,
    st_timer_pre,
    st_write_sector,
    st_timer_post,
    st_write_reset,
    st_wait
  } fws_state_t;

  fws_state_t state;
  fws_state_t next_state;
  logic [ADDR_W-1:0] target;
  logic [ADDR_W-1:0] next_target;
  logic [ADDR_W-1:0] sector;
  logic [ADDR_W-1:0] next_sector;
  logic erase_mode;
  logic next_erase_mode;
  logic add_pending;
  logic next_add_pending;
  logic first_tog;
  logic next_first_tog;
  logic [DATA_W-1:0] last_status;
  logic [DATA_W-1:0] next_last_status;
  logic [1:0] result;
  logic [1:0] next_result;
  logic [`FWS_IRQ_WIDTH-1:0] irq_status;
  logic [`FWS_IRQ_WIDTH-1:0] next_irq_status;
  logic [`FWS_IRQ_WIDTH-1:0] irq_mask;
  logic [`FWS_IRQ_WIDTH-1:0] next_irq_mask;
  logic [`FWS_IRQ_WIDTH-1:0] irq_set;
  logic [31:0] next_reg_rdata;
  logic next_irq;
  logic cyc_go;
  logic cyc_write;
  logic [ADDR_W-1:0] cyc_addr;
  logic [DATA_W-1:0] cyc_wdata;
  logic cyc_done;
  logic [DATA_W-1:0] cyc_rdata;
  logic tog_now;
  logic issued;
  logic next_issued;
  // An abort is held here until the flash bus sits between two cycles, so that
  // software may write it at any time without cutting a strobe short.
  logic abort_req;
  logic next_abort_req;

  fws_bus_cycle #(
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W)
  ) u_cycle (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .go(cyc_go),
    .is_write(cyc_write),
    .addr(cyc_addr),
    .wdata(cyc_wdata),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .flash_addr(flash_addr),
    .chip_select_n(chip_select_n),
    .output_enable_n(output_enable_n),
    .write_strobe_n(write_strobe_n),
    .data_bus_out(data_bus_out),
    .data_bus_oe_n(data_bus_oe_n),
    .data_bus_in(data_bus_in)
  );

  // In erase mode the toggle bit of interest is the sector one, else the mode one.
  assign tog_now = erase_mode ? cyc_rdata[`FWS_BIT_TOG2] : cyc_rdata[`FWS_BIT_TOG1]; // [RQ3]

  // Polling sequencer. Reads always target the busy bank at the given address,
  // since any other bank answers with plain array data. [RQ16] [RQ17]
  always_comb begin
    next_state = state;
    next_target = target;
    next_sector = sector;
    next_erase_mode = erase_mode;
    next_add_pending = add_pending;
    next_first_tog = first_tog;
    next_last_status = last_status;
    next_result = result;
    next_issued = 1'b0;
    next_abort_req = abort_req;
    irq_set = '0;
    cyc_go = 1'b0;
    cyc_write = 1'b0;
    cyc_addr = target;
    cyc_wdata = '0;
    if (reg_write && reg_addr == `FWS_REG_ADDR) begin
      if (state == st_idle || state == st_wait) begin
        next_target = reg_wdata[ADDR_W-1:0];
      end
      next_sector = reg_wdata[ADDR_W-1:0];
    end
    if (reg_write && reg_addr == `FWS_REG_CTRL && reg_wdata[`FWS_CTRL_ADD_SECTOR]) begin
      next_add_pending = 1'b1;
    end
    // Issue one cycle per state entry; issued blocks re-issue until done.
    if (state != st_idle && state != st_wait && !issued && !cyc_done) begin
      cyc_go = 1'b1;
      next_issued = 1'b1;
    end else if (issued && !cyc_done) begin
      next_issued = 1'b1;
    end
    if (state == st_write_sector) begin
      cyc_write = 1'b1;
      cyc_addr = sector;
      cyc_wdata = `FWS_SECTOR_ERASE_DATA;
    end else if (state == st_write_reset) begin
      cyc_write = 1'b1;
      cyc_wdata = `FWS_RESET_DATA; // [RQ9]
    end
    unique case (state)
      st_idle, st_wait: begin
        // A new start always begins with a fresh double read. [RQ6]
        if (reg_write && reg_addr == `FWS_REG_CTRL && reg_wdata[`FWS_CTRL_START]) begin
          next_erase_mode = reg_wdata[`FWS_CTRL_ERASE];
          next_result = 2'(fws_pkg::fws_res_busy);
          next_state = st_read_first;
        end
      end
      st_read_first: begin
        // First read of a pair: keep its toggle bit for the comparison.
        if (cyc_done) begin
          next_first_tog = tog_now;
          next_state = st_read_second;
        end
      end
      st_read_second: begin
        if (cyc_done) begin
          next_last_status = cyc_rdata;
          if (tog_now == first_tog) begin
            next_result = 2'(fws_pkg::fws_res_done); // [RQ4]
            irq_set[`FWS_IRQ_DONE] = 1'b1;
            next_state = st_idle;
          end else if (cyc_rdata[`FWS_BIT_TIMEOUT]) begin
            next_first_tog = tog_now;
            next_state = st_read_third; // [RQ5]
          end else if (erase_mode && add_pending) begin
            next_state = st_timer_pre; // [RQ13]
          end else begin
            next_state = st_read_first;
          end
        end
      end
      st_read_third: begin
        // Re-test after the timeout flag, as the bit may stop just as the flag rises.
        if (cyc_done) begin
          next_first_tog = tog_now;
          next_state = st_read_fourth;
        end
      end
      st_read_fourth: begin
        if (cyc_done) begin
          next_last_status = cyc_rdata;
          if (tog_now == first_tog) begin
            next_result = 2'(fws_pkg::fws_res_done);
            irq_set[`FWS_IRQ_DONE] = 1'b1;
            next_state = st_idle;
          end else begin
            next_result = 2'(fws_pkg::fws_res_fail); // [RQ5]
            irq_set[`FWS_IRQ_FAIL] = 1'b1;
            next_state = st_write_reset;
          end
        end
      end
      st_timer_pre: begin
        // The timer is always read, since nothing here bounds the gap between added
        // sector commands below the acceptance time-out. [RQ11]
        // Timer already expired means erase began; the added sector is refused.
        if (cyc_done) begin
          next_last_status = cyc_rdata;
          next_add_pending = 1'b0;
          if (cyc_rdata[`FWS_BIT_ETIMER]) begin
            next_result = 2'(fws_pkg::fws_res_reject); // [RQ12]
            irq_set[`FWS_IRQ_REJECT] = 1'b1;
            next_state = st_read_first;
          end else begin
            next_state = st_write_sector;
          end
        end
      end
      st_write_sector: begin
        // One-cycle added sector command at the sector address.
        if (cyc_done) begin
          next_state = st_timer_post;
        end
      end
      st_timer_post: begin
        // Timer high right after the write: the command may not have been taken.
        if (cyc_done) begin
          next_last_status = cyc_rdata;
          if (cyc_rdata[`FWS_BIT_ETIMER] && !ready_busy_pin) begin
            next_result = 2'(fws_pkg::fws_res_reject); // [RQ14]
            irq_set[`FWS_IRQ_REJECT] = 1'b1;
          end
          next_state = st_read_first;
        end
      end
      st_write_reset: begin
        // The reset word returns the bank to reading array data.
        if (cyc_done) begin
          next_state = st_idle;
        end
      end
      default: begin
        next_state = st_idle;
      end
    endcase
    // Software abort leaves polling; a later start restarts from the top. [RQ6]
    // The request waits until the flash bus is between two cycles, so no strobe is
    // cut short, but an abort taken as the failing fourth read ends skips the reset word. [RQ9]
    if (reg_write && reg_addr == `FWS_REG_CTRL && reg_wdata[`FWS_CTRL_ABORT]) begin
      next_abort_req = 1'b1;
    end
    if (state == st_idle || state == st_wait) begin
      next_abort_req = 1'b0;
    end else if (abort_req && state != st_write_reset && issued == cyc_done) begin
      // Either nothing has been issued yet, or the last cycle has just ended.
      next_abort_req = 1'b0;
      cyc_go = 1'b0;
      next_issued = 1'b0;
      next_state = st_wait;
    end
  end

  // Sticky interrupts: set wins over the clear-on-read in the same cycle.
  always_comb begin
    next_irq_mask = irq_mask;
    next_irq_status = irq_status;
    if (reg_read && reg_addr == `FWS_REG_IRQ) begin
      next_irq_status = '0;
    end
    next_irq_status = next_irq_status | irq_set;
    // A mask write reaches irq at the same edge as the new mask itself.
    if (reg_write && reg_addr == `FWS_REG_MASK) begin
      next_irq_mask = reg_wdata[`FWS_IRQ_WIDTH-1:0];
    end
    next_irq = |(next_irq_status & next_irq_mask);
  end

  // Read data appears the cycle after the strobe; unmapped offsets read zero.
  always_comb begin
    next_reg_rdata = 32'h0000_0000;
    if (reg_read) begin
      unique case (reg_addr)
        `FWS_REG_CTRL: next_reg_rdata = {31'h0, erase_mode};
        `FWS_REG_ADDR: next_reg_rdata = 32'(target);
        `FWS_REG_STATUS: next_reg_rdata = {27'h0, add_pending, ready_busy_pin,
                                           state == st_idle, result};
        `FWS_REG_IRQ: next_reg_rdata = 32'(irq_status);
        `FWS_REG_MASK: next_reg_rdata = 32'(irq_mask);
        `FWS_REG_LAST: next_reg_rdata = 32'(last_status);
        default: next_reg_rdata = 32'h0000_0000;
      endcase
    end
  end

  // State registers; every top-level output leaves a flip-flop, here or in the
  // bus cycle module, so nothing combinational reaches a pin.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= st_idle;
      target <= '0;
      sector <= '0;
      erase_mode <= 1'b0;
      add_pending <= 1'b0;
      first_tog <= 1'b0;
      last_status <= '0;
      result <= 2'h0;
      issued <= 1'b0;
      abort_req <= 1'b0;
      irq_status <= '0;
      irq_mask <= '0;
      irq <= 1'b0;
      reg_rdata <= 32'h0000_0000;
    end else begin
      state <= next_state;
      target <= next_target;
      sector <= next_sector;
      erase_mode <= next_erase_mode;
      add_pending <= next_add_pending;
      first_tog <= next_first_tog;
      last_status <= next_last_status;
      result <= next_result;
      issued <= next_issued;
      abort_req <= next_abort_req;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      irq <= next_irq;
      reg_rdata <= next_reg_rdata;
    end
  end
endmodule : fws_ctrl

// >>> testbench/fws_ctrl_sva.sv
// Port-level checks for the flash write-status polling controller.
`timescale 1ns/1ps
module fws_ctrl_sva #(
  parameter int ADDR_W = 22,
  parameter int DATA_W = 16
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic irq,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic chip_select_n,
  input wire logic output_enable_n,
  input wire logic write_strobe_n,
  input wire logic [DATA_W-1:0] data_bus_out,
  input wire logic data_bus_oe_n
);
  logic [1:0] reads_seen;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Flash reads since the last flash write; saturates so it never wraps.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reads_seen <= 2'h0;
    end else if ($fell(write_strobe_n)) begin
      reads_seen <= 2'h0;
    end else if ($fell(output_enable_n) && reads_seen != 2'h3) begin
      reads_seen <= reads_seen + 2'h1;
    end
  end
  // Strobe shape, bus ownership and command words.
  strobe_excl_a: assert property (output_enable_n || write_strobe_n)
    else $error("read and write strobes low together");
  bus_drive_a: assert property (data_bus_oe_n == write_strobe_n)
    else $error("data bus driven outside a write");
  select_cover_a: assert property (
    !(output_enable_n && write_strobe_n) |-> !chip_select_n)
    else $error("strobe low without chip select");
  read_width_a: assert property (
    $fell(output_enable_n) |-> ##1 !output_enable_n ##1 output_enable_n)
    else $error("read strobe not two cycles");
  write_width_a: assert property ($fell(write_strobe_n) |->
    ##1 (!write_strobe_n && $stable(data_bus_out)) ##1 write_strobe_n)
    else $error("write strobe or data unstable");
  addr_hold_a: assert property (
    !chip_select_n && !$past(chip_select_n) |-> $stable(flash_addr))
    else $error("address moved inside a flash cycle");
  command_word_a: assert property (
    $fell(write_strobe_n) |-> data_bus_out inside {16'h00f0, 16'h0030})
    else $error("unexpected command word");
  double_read_a: assert property ($fell(write_strobe_n) |-> reads_seen >= 2'h2)
    else $error("write without a preceding double read");
  rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  read_seen_c: cover property ($fell(output_enable_n));
  reset_word_c: cover property ($fell(write_strobe_n) && data_bus_out == 16'h00f0);
  sector_word_c: cover property ($fell(write_strobe_n) && data_bus_out == 16'h0030);
  irq_rise_c: cover property ($rose(irq));
endmodule : fws_ctrl_sva
bind fws_ctrl fws_ctrl_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk_u (
  .sys_clk(sys_clk), .reset_n(reset_n), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .irq(irq), .flash_addr(flash_addr), .chip_select_n(chip_select_n),
  .output_enable_n(output_enable_n), .write_strobe_n(write_strobe_n),
  .data_bus_out(data_bus_out), .data_bus_oe_n(data_bus_oe_n));

// >>> testbench/fws_flash_model.sv
// Behavioural flash device answering status reads for the polling controller.
`timescale 1ns/1ps
module fws_flash_model (
  input wire logic sys_clk,
  input wire logic [21:0] flash_addr,
  input wire logic chip_select_n,
  input wire logic output_enable_n,
  input wire logic write_strobe_n,
  input wire logic [15:0] data_bus_out,
  output logic [15:0] data_bus_in,
  output logic ready_busy_pin,
  input wire logic ld,
  input wire logic [7:0] ld_cfg,
  output int reset_cnt = 0,
  output int sector_cnt = 0,
  output logic [21:0] last_addr = 22'h0
);
  logic busy = 1'b0, fail = 1'b0, erase = 1'b0, etim = 1'b0, tmo = 1'b0;
  logic tog1 = 1'b0, tog2 = 1'b0, rd_q = 1'b0, wr_q = 1'b0, late = 1'b0;
  logic [15:0] word, wdat = 16'h0, last = 16'h0;
  logic rd, sel;
  int left = 0;
  // Only the lower bank runs the algorithm; the other gives array data.
  assign sel = busy && !flash_addr[21];
  assign rd = !chip_select_n && !output_enable_n;
  // Polling 0, timeout, timer and toggles, valid from the command on.
  assign word = sel ? {9'h0, tog1, tmo, 1'b0, etim & erase, tog2 & erase, 2'b00} : 16'h5a3c;
  // A released bus shows the inverse of the last value, so stale reads fail.
  assign data_bus_in = rd ? word : ~last;
  // Open-drain busy pulls low; the pull-up gives ready.
  assign ready_busy_pin = !busy;
  // Loads, end of read cycles and accepted command words.
  always @(posedge sys_clk) begin
    rd_q <= rd;
    wr_q <= !chip_select_n && !write_strobe_n;
    if (rd) last <= word;
    if (rd) last_addr <= flash_addr;
    if (!write_strobe_n) wdat <= data_bus_out;
    if (ld) begin
      busy <= 1'b1;
      // Load word: [3:0] reads left, [4] timer runs out as the next sector word lands.
      left <= int'(ld_cfg[3:0]);
      late <= ld_cfg[4];
      fail <= ld_cfg[5];
      erase <= ld_cfg[6];
      etim <= ld_cfg[7];
      tmo <= 1'b0;
    end else if (rd_q && !rd && sel) begin
      tog1 <= ~tog1;
      tog2 <= ~tog2; // Seen only in the erase-selected sector.
      left <= left - 1;
      if (left == 1) begin
        busy <= fail; // A stalled 0-to-1 program never ends by itself.
        tmo <= fail;
      end
    end else if (wr_q && write_strobe_n) begin
      if (wdat == 16'h00f0) begin
        busy <= 1'b0;
        tmo <= 1'b0;
        reset_cnt <= reset_cnt + 1;
      end else if (wdat == 16'h0030 && !etim && late) begin
        etim <= 1'b1; // The time-out won the race: erase began, the word is lost.
      end else if (wdat == 16'h0030 && !etim) begin
        sector_cnt <= sector_cnt + 1; // Timer restarts and still reads 0.
      end
    end
  end
endmodule : fws_flash_model

// >>> testbench/test_flash_write_status_reporting.sv
// Self-checking bench for the flash write-status polling controller.
`timescale 1ns/1ps
module test_flash_write_status_reporting;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic ld = 1'b0;
  logic [7:0] ld_cfg = 8'h00;
  logic [31:0] reg_rdata, s;
  logic irq, chip_select_n, output_enable_n, write_strobe_n, ready_busy_pin;
  logic [21:0] flash_addr, last_addr;
  logic [15:0] data_bus_out, data_bus_in;
  int reset_cnt, sector_cnt;
  int miscompares = 0;
  int cmp_count = 0;
  int oe_falls = 0;
  int n;
  always #50 sys_clk = ~sys_clk;
  // Flash reads started, counted to show that an abort leaves the bus quiet.
  always @(negedge output_enable_n) oe_falls++;
  fws_ctrl dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .irq(irq), .flash_addr(flash_addr),
    .chip_select_n(chip_select_n), .output_enable_n(output_enable_n),
    .write_strobe_n(write_strobe_n), .data_bus_out(data_bus_out), .data_bus_oe_n(),
    .data_bus_in(data_bus_in), .ready_busy_pin(ready_busy_pin));
  fws_flash_model mdl_u (.sys_clk(sys_clk), .flash_addr(flash_addr),
    .chip_select_n(chip_select_n), .output_enable_n(output_enable_n),
    .write_strobe_n(write_strobe_n), .data_bus_out(data_bus_out),
    .data_bus_in(data_bus_in), .ready_busy_pin(ready_busy_pin), .ld(ld),
    .ld_cfg(ld_cfg), .reset_cnt(reset_cnt), .sector_cnt(sector_cnt), .last_addr(last_addr));
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe, so sample just past that edge.
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1 s = reg_rdata;
  endtask : rd
  task automatic load(input logic [7:0] c);
    @(posedge sys_clk);
    ld_cfg <= c;
    ld <= 1'b1;
    @(posedge sys_clk);
    ld <= 1'b0;
  endtask : load
  // Polls the result field under a bounded count.
  task automatic wait_res;
    for (int i = 0; i < 300; i++) begin
      rd(4'h2);
      if (s[1:0] !== 2'b00) break;
    end
  endtask : wait_res
  // Polls the idle flag under a bounded count; running out is a mismatch.
  task automatic wait_idle;
    for (int i = 0; i < 300; i++) begin
      rd(4'h2);
      if (s[2] === 1'b1) break;
    end
    cmp("idle after run", 32'h1, {31'h0, s[2]});
  endtask : wait_idle
  // Main sequence: reset, done, timeout failure, abort, added sector, two rejections.
  initial begin
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(4'h2);
    cmp("idle and ready", 32'h3, {30'h0, s[3:2]});
    cmp("irq at reset", 32'h0, {31'h0, irq});
    rd(4'hf);
    cmp("unmapped read", 32'h0, s);
    wr(4'h4, 32'h0);
    wr(4'h1, 32'h100);
    load(8'h05);
    rd(4'h2);
    cmp("busy pin", 32'h0, {31'h0, s[3]});
    wr(4'h0, 32'h1);
    wait_res;
    cmp("done result", 32'h1, {30'h0, s[1:0]});
    cmp("masked irq", 32'h0, {31'h0, irq});
    rd(4'h5);
    cmp("array after done", 32'h5a3c, s);
    cmp("poll address", 32'h100, {10'h0, last_addr});
    wr(4'h4, 32'h7);
    rd(4'h2);
    cmp("irq raised", 32'h1, {31'h0, irq});
    rd(4'h3);
    cmp("done flag", 32'h1, s);
    rd(4'h3);
    cmp("flags cleared", 32'h0, s);
    cmp("irq cleared", 32'h0, {31'h0, irq});
    // The program stalls with the timeout flag up; a reset word must follow.
    load(8'h23);
    wr(4'h0, 32'h1);
    wait_res;
    cmp("fail result", 32'h2, {30'h0, s[1:0]});
    for (int i = 0; i < 20 && reset_cnt == 0; i++) @(posedge sys_clk);
    cmp("reset words", 32'h1, 32'(reset_cnt));
    rd(4'h2);
    cmp("irq on fail", 32'h1, {31'h0, irq});
    rd(4'h3);
    cmp("fail flag", 32'h2, s);
    // Abort leaves the flash bus quiet; a new start polls again from the top.
    load(8'h0f);
    wr(4'h0, 32'h1);
    wr(4'h0, 32'h8);
    repeat (6) @(posedge sys_clk);
    n = oe_falls;
    repeat (20) @(posedge sys_clk);
    cmp("reads after abort", n, oe_falls);
    rd(4'h2);
    cmp("aborted status", 32'h0, {29'h0, s[2:0]});
    wr(4'h0, 32'h1);
    wait_res;
    cmp("restart result", 32'h1, {30'h0, s[1:0]});
    // Erase with one added sector while the timer still reads 0.
    load(8'h48);
    wr(4'h0, 32'h7);
    wait_res;
    cmp("erase result", 32'h1, {30'h0, s[1:0]});
    cmp("sector words", 32'h1, 32'(sector_cnt));
    // Timer already at 1 before the command: reject, and no word is written.
    load(8'hc8);
    wr(4'h0, 32'h7);
    wait_res;
    cmp("reject result", 32'h3, {30'h0, s[1:0]});
    cmp("sector words", 32'h1, 32'(sector_cnt));
    wait_idle;
    rd(4'h3);
    cmp("done and reject flags", 32'h5, s);
    // Timer runs out as the added sector lands: the check after the write rejects.
    load(8'h58);
    wr(4'h0, 32'h7);
    wait_res;
    cmp("late reject result", 32'h3, {30'h0, s[1:0]});
    cmp("late sector words", 32'h1, 32'(sector_cnt));
    wait_idle;
    rd(4'h3);
    cmp("late reject flags", 32'h5, s);
    end_of_test;
  end
  // Watchdog: the sequence needs far fewer than 30000 cycles.
  initial begin
    #3000000;
    miscompares++;
    end_of_test;
  end
endmodule : test_flash_write_status_reporting
